// ==== design/map_pkg.sv ====
// constants shared by the memory address map and its program counter unit
// assumes a single 10 MHz clock and a synchronous active-high reset
package map_pkg;

  // program space
  localparam int PC_W = 10;                     // program counter width
  localparam int PROG_WORDS = 1024;             // program memory size
  localparam logic [9:0] VEC_RESET = 10'h000;   // power-on entry
  localparam logic [9:0] VEC_SW_IRQ = 10'h001;  // software interrupt entry
  localparam logic [9:0] VEC_HW_IRQ = 10'h008;  // hardware interrupt entry
  localparam int STACK_DEPTH = 8;               // hardware return stack levels

  // data page layout
  localparam int OFF_W = 6;                     // location bits within a bank
  localparam int BANK_MSB = 7;                  // bank bits in the pointer
  localparam int BANK_LSB = 6;
  localparam logic [5:0] SFR_LAST = 6'h0f;      // last special register offset
  localparam logic [5:0] GPR_FIRST = 6'h10;     // first general ram offset
  localparam int GPR_PER_BANK = 48;             // 0x10..0x3f
  localparam int GPR_BYTES = 96;                // two physical banks

  // general data page offsets
  localparam logic [5:0] OFF_INDIRECT = 6'h00;
  localparam logic [5:0] OFF_TIMER0 = 6'h01;
  localparam logic [5:0] OFF_PC_LOW = 6'h02;
  localparam logic [5:0] OFF_STATUS = 6'h03;
  localparam logic [5:0] OFF_PTR = 6'h04;
  localparam logic [5:0] OFF_PORT_A = 6'h05;
  localparam logic [5:0] OFF_PORT_B = 6'h06;
  localparam logic [5:0] OFF_HOLE_A = 6'h07;
  localparam logic [5:0] OFF_POWER = 6'h08;
  localparam logic [5:0] OFF_WAKE = 6'h09;
  localparam logic [5:0] OFF_PC_HIGH = 6'h0a;
  localparam logic [5:0] OFF_PLCON = 6'h0b;
  localparam logic [5:0] OFF_B_PULLUP = 6'h0c;
  localparam logic [5:0] OFF_HOLE_B = 6'h0d;
  localparam logic [5:0] OFF_IRQ_EN = 6'h0e;
  localparam logic [5:0] OFF_IRQ_FLAG = 6'h0f;

  // second page: implemented offsets as a bit mask (5,6,9,a,c,e,f)
  localparam logic [15:0] FPAGE_IMPL = 16'hd660;
  localparam int PAGE_ADDR_W = 4;               // second/third page offset bits

  // reset values
  localparam logic [7:0] STATUS_RST = 8'h18;    // to and pd flags set
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;       // all pins input

  // port bit positions used by the pin multiplexer
  localparam int PB_INT = 0;
  localparam int PB_IR = 1;
  localparam int PB_CK2 = 3;
  localparam int PB_PULSE2 = 4;
  localparam int PB_BUZZ2 = 5;
  localparam int PB_PULSE1 = 6;
  localparam int PB_BUZZ1 = 7;
  localparam int PA_CK01 = 4;
  localparam int PA_RST = 5;
  localparam int PA_ICLK = 7;

  // which page an access targets
  typedef enum logic [1:0] {page_r, page_f, page_s} page_e;

  // program counter operations issued by the core
  typedef enum logic [3:0] {
    op_hold, op_step, op_short_jump, op_short_call, op_acc_jump, op_acc_call,
    op_long_jump, op_long_call, op_return, op_sw_irq, op_hw_irq
  } pc_op_e;

endpackage

// ==== design/pc_sequencer.sv ====
// program counter and hardware return stack
// assumes the core issues one operation per enabled cycle
module pc_sequencer import map_pkg::*; #(
  parameter int DEPTH = STACK_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // operation from the core
  input wire pc_op_e pc_op,
  input wire logic [PC_W-1:0] target,
  input wire logic [7:0] acc,
  input wire logic [1:0] page_bits,
  input wire logic low_wr,
  input wire logic [7:0] low_data,
  // current address
  output logic [PC_W-1:0] pc
);

  localparam int SP_W = $clog2(DEPTH);

  typedef struct packed {
    logic [PC_W-1:0] pc;                      // program counter
    logic [SP_W-1:0] sp;                      // next free stack slot
    logic [DEPTH-1:0][PC_W-1:0] stack;        // return addresses
  } seq_s;

  seq_s state_ff;
  seq_s nxt_state;

  // next state: jumps, calls, returns, vectors
  always_comb begin
    logic [PC_W-1:0] ret_addr;
    ret_addr = state_ff.pc + 10'h001;
    nxt_state = state_ff;
    if (ce) begin
      if (low_wr) begin
        // writing the low byte takes the upper bits from the buffer
        nxt_state.pc = {page_bits, low_data};
      end else begin
        case (pc_op)
          op_step: nxt_state.pc = ret_addr;
          op_short_jump: nxt_state.pc = {page_bits[1], target[8:0]};
          op_short_call: begin
            nxt_state.pc = {page_bits, target[7:0]};
            nxt_state.stack[state_ff.sp] = ret_addr;
            nxt_state.sp = state_ff.sp + 1'b1;
          end
          op_acc_jump: nxt_state.pc = {page_bits, acc};
          op_acc_call: begin
            nxt_state.pc = {page_bits, acc};
            nxt_state.stack[state_ff.sp] = ret_addr;
            nxt_state.sp = state_ff.sp + 1'b1;
          end
          op_long_jump: nxt_state.pc = target;
          op_long_call: begin
            nxt_state.pc = target;
            nxt_state.stack[state_ff.sp] = ret_addr;
            nxt_state.sp = state_ff.sp + 1'b1;
          end
          op_return: begin
            // every return kind pops the top entry
            nxt_state.pc = state_ff.stack[state_ff.sp - 1'b1];
            nxt_state.sp = state_ff.sp - 1'b1;
          end
          op_sw_irq: begin
            nxt_state.pc = VEC_SW_IRQ;
            nxt_state.stack[state_ff.sp] = ret_addr;
            nxt_state.sp = state_ff.sp + 1'b1;
          end
          op_hw_irq: begin
            nxt_state.pc = VEC_HW_IRQ;
            nxt_state.stack[state_ff.sp] = ret_addr;
            nxt_state.sp = state_ff.sp + 1'b1;
          end
          default: nxt_state.pc = state_ff.pc;  // hold
        endcase
      end
    end
  end

  // state register, stack wraps when overfilled
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.pc <= VEC_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pc = state_ff.pc;

endmodule

// ==== design/mcu_memory_address_map.sv ====
// banked data memory decode, special register pages, program counter and pin functions
// assumes the core drives one data access and one pc operation per enabled cycle
module mcu_memory_address_map import map_pkg::*; #(
  parameter int RAM_BYTES = GPR_BYTES
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // data access from the core
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire page_e acc_page,
  input wire logic [OFF_W-1:0] acc_opaddr,
  input wire logic [7:0] acc_wdata,
  output logic [7:0] acc_rdata,
  // program counter control from the core
  input wire pc_op_e pc_op,
  input wire logic [PC_W-1:0] pc_target,
  input wire logic [7:0] pc_acc,
  output logic [PC_W-1:0] pc,
  // port a pins
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  // port b pins
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  // pin function selects
  input wire logic external_irq_pin_select,
  input wire logic external_irq_enable,
  input wire logic reset_pin_en,
  input wire logic timer01_ext_sel,
  input wire logic timer2_ext_sel,
  input wire logic ir_mode_en,
  input wire logic ir_large_sink,
  input wire logic inst_clk_out_en,
  input wire logic pulse1_out_en,
  input wire logic cmp_out_en,
  input wire logic pulse2_out_en,
  input wire logic buzz1_out_en,
  input wire logic buzz2_out_en,
  // peripheral signals routed to pins
  input wire logic ir_carrier,
  input wire logic inst_clk,
  input wire logic pulse_output_one,
  input wire logic pulse_output_two,
  input wire logic comparator_output_pin,
  input wire logic buzzer_output_one,
  input wire logic buzzer_output_two,
  // pin functions routed to peripherals
  output logic external_irq_level,
  output logic external_reset_input_n,
  output logic timer01_external_clock,
  output logic timer2_external_clock,
  output logic ir_large_sink_drive
);

  // every register of the block
  typedef struct packed {
    logic [7:0] timer0;                       // timer0 count storage
    logic [7:0] status;                       // status flags
    logic [7:0] ptr;                          // file select pointer
    logic [7:0] pa_lat;                       // port a output latch
    logic [7:0] pb_lat;                       // port b output latch
    logic [7:0] power;                        // power control
    logic [7:0] wake;                         // port b wakeup control
    logic [7:0] pc_high;                      // pc high buffer
    logic [7:0] plcon;                        // pull low control
    logic [7:0] b_pullup;                     // port b pull high control
    logic [7:0] irq_en;                       // interrupt enable mask
    logic [7:0] irq_flag;                     // interrupt flags
    logic [15:0][7:0] fpg;                    // second page registers
    logic [15:0][7:0] spg;                    // third page registers
    logic [RAM_BYTES-1:0][7:0] gpr;           // general purpose ram
    logic [7:0] rdata;                        // read data register
  } map_s;

  map_s state_ff;
  map_s nxt_state;

  logic r_hit;                                // general page access this cycle
  logic [OFF_W-1:0] r_off;                    // effective location
  logic [1:0] r_bank;                         // effective bank
  logic low_wr;                               // low pc byte write

  // physical ram slot for a bank and location; banks 2 and 3 fold onto 0 and 1
  function automatic logic [6:0] gpr_slot(input logic [1:0] bank, input logic [OFF_W-1:0] off);
    logic [6:0] base;
    base = bank[0] ? 7'(GPR_PER_BANK) : 7'h00;
    gpr_slot = base + 7'(off - GPR_FIRST);
  endfunction

  // pin value when input, latch value when driven
  function automatic logic [7:0] port_read(input logic [7:0] pins, input logic [7:0] lat,
                                           input logic [7:0] dir);
    port_read = (pins & dir) | (lat & ~dir);
  endfunction

  // address formation for the general data page
  always_comb begin
    r_bank = state_ff.ptr[BANK_MSB:BANK_LSB];
    if (acc_opaddr == OFF_INDIRECT) begin
      r_off = state_ff.ptr[OFF_W-1:0];
    end else begin
      r_off = acc_opaddr;
    end
    r_hit = ce && acc_valid && (acc_page == page_r);
    low_wr = r_hit && acc_write && (r_off == OFF_PC_LOW);
  end

  // register reads and writes
  always_comb begin
    logic [7:0] rd;
    logic [6:0] slot;
    logic [PAGE_ADDR_W-1:0] pidx;
    rd = BYTE_ZERO;
    slot = gpr_slot(r_bank, r_off);
    pidx = acc_opaddr[PAGE_ADDR_W-1:0];  // bank bits play no part
    nxt_state = state_ff;
    if (ce && acc_valid) begin
      case (acc_page)
        page_r: begin
          if (r_off > SFR_LAST) begin
            // general ram, two physical banks
            if (acc_write) begin
              nxt_state.gpr[slot] = acc_wdata;
            end
            rd = state_ff.gpr[slot];
          end else begin
            // special registers ignore the bank: one copy only
            case (r_off)
              OFF_TIMER0: begin
                rd = state_ff.timer0;
                if (acc_write) nxt_state.timer0 = acc_wdata;
              end
              OFF_PC_LOW: rd = pc[7:0];  // write goes to the sequencer
              OFF_STATUS: begin
                rd = state_ff.status;
                if (acc_write) nxt_state.status = acc_wdata;
              end
              OFF_PTR: begin
                rd = state_ff.ptr;
                if (acc_write) nxt_state.ptr = acc_wdata;
              end
              OFF_PORT_A: begin
                rd = port_read(port_a_in, state_ff.pa_lat, state_ff.fpg[OFF_PORT_A[3:0]]);
                if (acc_write) nxt_state.pa_lat = acc_wdata;
              end
              OFF_PORT_B: begin
                rd = port_read(port_b_in, state_ff.pb_lat, state_ff.fpg[OFF_PORT_B[3:0]]);
                if (acc_write) nxt_state.pb_lat = acc_wdata;
              end
              OFF_POWER: begin
                rd = state_ff.power;
                if (acc_write) nxt_state.power = acc_wdata;
              end
              OFF_WAKE: begin
                rd = state_ff.wake;
                if (acc_write) nxt_state.wake = acc_wdata;
              end
              OFF_PC_HIGH: begin
                rd = state_ff.pc_high;
                if (acc_write) nxt_state.pc_high = acc_wdata;
              end
              OFF_PLCON: begin
                rd = state_ff.plcon;
                if (acc_write) nxt_state.plcon = acc_wdata;
              end
              OFF_B_PULLUP: begin
                rd = state_ff.b_pullup;
                if (acc_write) nxt_state.b_pullup = acc_wdata;
              end
              OFF_IRQ_EN: begin
                rd = state_ff.irq_en;
                if (acc_write) nxt_state.irq_en = acc_wdata;
              end
              OFF_IRQ_FLAG: begin
                rd = state_ff.irq_flag;
                if (acc_write) nxt_state.irq_flag = acc_wdata;
              end
              // holes at 7 and d, and the indirect port pointing at itself
              default: rd = BYTE_ZERO;
            endcase
          end
        end
        page_f: begin
          // reached only by the second page ops
          if (FPAGE_IMPL[pidx]) begin
            rd = state_ff.fpg[pidx];
            if (acc_write) nxt_state.fpg[pidx] = acc_wdata;
          end else begin
            rd = BYTE_ZERO;
          end
        end
        page_s: begin
          // reached only by the third page ops
          rd = state_ff.spg[pidx];
          if (acc_write) nxt_state.spg[pidx] = acc_wdata;
        end
        default: rd = BYTE_ZERO;
      endcase
      nxt_state.rdata = rd;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.status <= STATUS_RST;
      state_ff.fpg[OFF_PORT_A[3:0]] <= DIR_RST;
      state_ff.fpg[OFF_PORT_B[3:0]] <= DIR_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // program counter and stack; rolling code words are plain program space
  pc_sequencer #(
    .DEPTH(STACK_DEPTH)
  ) u_seq (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pc_op(pc_op),
    .target(pc_target),
    .acc(pc_acc),
    .page_bits(state_ff.pc_high[1:0]),
    .low_wr(low_wr),
    .low_data(acc_wdata),
    .pc(pc)
  );

  assign acc_rdata = state_ff.rdata;

  // pin multiplexing: direction bit 1 means input
  always_comb begin
    logic [7:0] a_dir;
    logic [7:0] b_dir;
    a_dir = state_ff.fpg[OFF_PORT_A[3:0]];
    b_dir = state_ff.fpg[OFF_PORT_B[3:0]];
    port_a_out = state_ff.pa_lat;
    port_a_oe = ~a_dir;
    port_b_out = state_ff.pb_lat;
    port_b_oe = ~b_dir;
    // pa5 only sinks; never drives high
    port_a_out[PA_RST] = 1'b0;
    port_a_oe[PA_RST] = ~a_dir[PA_RST] & ~state_ff.pa_lat[PA_RST] & ~reset_pin_en;
    if (inst_clk_out_en) begin
      port_a_out[PA_ICLK] = inst_clk;
      port_a_oe[PA_ICLK] = 1'b1;
    end
    if (ir_mode_en) begin
      port_b_out[PB_IR] = ir_carrier;
      port_b_oe[PB_IR] = 1'b1;
    end
    if (pulse1_out_en) begin
      port_b_out[PB_PULSE1] = pulse_output_one;
      port_b_oe[PB_PULSE1] = 1'b1;
    end else if (cmp_out_en) begin
      port_b_out[PB_PULSE1] = comparator_output_pin;
      port_b_oe[PB_PULSE1] = 1'b1;
    end
    if (pulse2_out_en) begin
      port_b_out[PB_PULSE2] = pulse_output_two;
      port_b_oe[PB_PULSE2] = 1'b1;
    end
    if (buzz1_out_en) begin
      port_b_out[PB_BUZZ1] = buzzer_output_one;
      port_b_oe[PB_BUZZ1] = 1'b1;
    end
    if (buzz2_out_en) begin
      port_b_out[PB_BUZZ2] = buzzer_output_two;
      port_b_oe[PB_BUZZ2] = 1'b1;
    end
  end

  // pin functions toward the peripherals
  assign external_irq_level = port_b_in[PB_INT] & external_irq_pin_select & external_irq_enable;
  assign external_reset_input_n = reset_pin_en ? port_a_in[PA_RST] : 1'b1;
  assign timer01_external_clock = timer01_ext_sel & port_a_in[PA_CK01];
  assign timer2_external_clock = timer2_ext_sel & port_b_in[PB_CK2];
  assign ir_large_sink_drive = ir_mode_en & ir_large_sink;

endmodule

// ==== sim/mcu_memory_address_map_chk.sv ====
// port checks for the memory address map
// assumes binding onto mcu_memory_address_map
module mcu_memory_address_map_chk import map_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // core side
  input wire logic acc_valid,
  input wire pc_op_e pc_op,
  input wire logic [PC_W-1:0] pc_target,
  input wire logic [7:0] pc_acc,
  input wire logic [PC_W-1:0] pc,
  input wire logic [7:0] acc_rdata,
  // pins
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_b_out,
  input wire logic external_irq_pin_select,
  input wire logic external_irq_enable,
  input wire logic external_irq_level,
  input wire logic reset_pin_en,
  input wire logic external_reset_input_n,
  input wire logic ir_mode_en,
  input wire logic ir_carrier,
  input wire logic timer2_ext_sel,
  input wire logic timer2_external_clock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // enabled cycle with no data access, so no counter write competes
  wire logic quiet = ce && !acc_valid;
  rst_vec_a: assert property (disable iff (1'b0) rst |=> pc == VEC_RESET) else $error("pc off reset entry");
  sw_vec_a: assert property (quiet && pc_op == op_sw_irq |=> pc == VEC_SW_IRQ) else $error("bad sw entry");
  hw_vec_a: assert property (quiet && pc_op == op_hw_irq |=> pc == VEC_HW_IRQ) else $error("bad hw entry");
  long_jmp_a: assert property (quiet && pc_op == op_long_jump |=> pc == $past(pc_target))
    else $error("long jump target lost");
  short_jmp_a: assert property (quiet && pc_op == op_short_jump |=> pc[8:0] == $past(pc_target[8:0]))
    else $error("short jump low bits wrong");
  short_call_a: assert property (quiet && pc_op == op_short_call |=> pc[7:0] == $past(pc_target[7:0]))
    else $error("short call low bits wrong");
  acc_jmp_a: assert property (quiet && pc_op inside {op_acc_jump, op_acc_call} |=> pc[7:0] == $past(pc_acc))
    else $error("accumulator branch wrong");
  call_ret_a: assert property (quiet && pc_op == op_long_call ##1 quiet && pc_op == op_hold
    ##1 quiet && pc_op == op_return |=> pc == $past(pc, 3) + 10'h001) else $error("return address wrong");
  freeze_a: assert property (!ce |=> $stable(pc) && $stable(acc_rdata)) else $error("state moved while disabled");
  irq_pin_a: assert property (external_irq_level ==
    (port_b_in[0] && external_irq_pin_select && external_irq_enable)) else $error("irq pin gating wrong");
  pa5_od_a: assert property (port_a_out[5] == 1'b0) else $error("open drain pin driven high");
  rst_pin_a: assert property (reset_pin_en |-> external_reset_input_n == port_a_in[5])
    else $error("reset pin not routed");
  ir_pin_a: assert property (ir_mode_en |-> port_b_out[1] == ir_carrier) else $error("carrier not on pin");
  t2_clk_a: assert property (timer2_external_clock == (timer2_ext_sel && port_b_in[3]))
    else $error("timer2 clock routing wrong");
  // main scenarios
  cover property (quiet && pc_op == op_long_call ##1 quiet && pc_op == op_hold ##1 quiet && pc_op == op_return);
  cover property (quiet && pc_op == op_hw_irq);
  cover property (!ce);
endmodule

bind mcu_memory_address_map mcu_memory_address_map_chk u_chk (.clk, .rst, .ce, .acc_valid, .pc_op, .pc_target,
  .pc_acc, .pc, .acc_rdata, .port_a_in, .port_a_out, .port_b_in, .port_b_out, .external_irq_pin_select,
  .external_irq_enable, .external_irq_level, .reset_pin_en, .external_reset_input_n, .ir_mode_en,
  .ir_carrier, .timer2_ext_sel, .timer2_external_clock);

// ==== sim/core_model.sv ====
// core model: issues data accesses and program counter operations
// assumes callers use one task at a time
module core_model import map_pkg::*; (
  // clock and answer
  input wire logic clk,
  input wire logic [7:0] acc_rdata,
  // requests
  output logic ce,
  output logic acc_valid,
  output logic acc_write,
  output page_e acc_page,
  output logic [OFF_W-1:0] acc_opaddr,
  output logic [7:0] acc_wdata,
  output pc_op_e pc_op,
  output logic [PC_W-1:0] pc_target,
  output logic [7:0] pc_acc
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle values at time zero
  initial begin
    ce = 1'b1;
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_page = page_r;
    acc_opaddr = 6'h00;
    acc_wdata = 8'h00;
    pc_op = op_hold;
    pc_target = 10'h000;
    pc_acc = 8'h00;
  end
  // one access, taken at a single edge
  task automatic access(input logic w, input page_e pg, input logic [5:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_page <= pg;
    acc_opaddr <= a;
    acc_wdata <= d;
    @(posedge clk);
    acc_valid <= 1'b0;
    acc_wdata <= ~d;  // released data shows no stale value
    @(negedge clk);
    q = acc_rdata;
  endtask
  // one counter operation; e low freezes the map
  task automatic pc_do(input pc_op_e op, input logic [9:0] t, input logic [7:0] a, input logic e);
    @(posedge clk);
    ce <= e;
    pc_op <= op;
    pc_target <= (t > 10'h3fd) ? 10'h3fd : t;  // firmware avoids the top two words
    pc_acc <= a;
    @(posedge clk);
    ce <= 1'b1;
    pc_op <= op_hold;
    @(negedge clk);
  endtask
endmodule

// ==== sim/mcu_memory_address_map_bench.sv ====
// self-checking bench for the memory address map
// assumes core_model drives the core side
module mcu_memory_address_map_bench import map_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, ce, acc_valid, acc_write;
  page_e acc_page;
  pc_op_e pc_op;
  logic [5:0] acc_opaddr;
  logic [7:0] acc_wdata, acc_rdata, pc_acc, pa_in, pb_in, pa_out, pa_oe, pb_out, pb_oe, q;
  logic [9:0] pc_target, pc;
  logic [12:0] sel;  // function selects, port order
  logic [6:0] per;  // peripheral levels, port order
  logic irq_lvl, rst_pin_n, t01ck, t2ck, irsink;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  // device under test
  mcu_memory_address_map u_mcu_memory_address_map (.clk(clk), .rst(rst), .ce(ce), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_page(acc_page), .acc_opaddr(acc_opaddr), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .pc_op(pc_op), .pc_target(pc_target), .pc_acc(pc_acc), .pc(pc),
    .port_a_in(pa_in), .port_a_out(pa_out), .port_a_oe(pa_oe), .port_b_in(pb_in), .port_b_out(pb_out),
    .port_b_oe(pb_oe), .external_irq_pin_select(sel[0]), .external_irq_enable(sel[1]),
    .reset_pin_en(sel[2]), .timer01_ext_sel(sel[3]), .timer2_ext_sel(sel[4]), .ir_mode_en(sel[5]),
    .ir_large_sink(sel[6]), .inst_clk_out_en(sel[7]), .pulse1_out_en(sel[8]), .cmp_out_en(sel[9]),
    .pulse2_out_en(sel[10]), .buzz1_out_en(sel[11]), .buzz2_out_en(sel[12]), .ir_carrier(per[0]),
    .inst_clk(per[1]), .pulse_output_one(per[2]), .pulse_output_two(per[3]), .comparator_output_pin(per[4]),
    .buzzer_output_one(per[5]), .buzzer_output_two(per[6]), .external_irq_level(irq_lvl),
    .external_reset_input_n(rst_pin_n), .timer01_external_clock(t01ck), .timer2_external_clock(t2ck),
    .ir_large_sink_drive(irsink));
  // core side model
  core_model u_core_model (.clk(clk), .acc_rdata(acc_rdata), .ce(ce), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_page(acc_page), .acc_opaddr(acc_opaddr), .acc_wdata(acc_wdata),
    .pc_op(pc_op), .pc_target(pc_target), .pc_acc(pc_acc));
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // compare tasks
  task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_pc(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t pc=%h exp=%h", $time, got, exp);
    end
  endtask
  // register access and counter steps
  task automatic wr(input page_e pg, input logic [5:0] a, input logic [7:0] d);
    u_core_model.access(1'b1, pg, a, d, q);
  endtask
  task automatic rd(input page_e pg, input logic [5:0] a, input logic [7:0] exp);
    u_core_model.access(1'b0, pg, a, 8'h00, q);
    cmp_data(q, exp);
  endtask
  task automatic op(input pc_op_e o, input logic [9:0] t, input logic [7:0] a, input logic [9:0] exp);
    u_core_model.pc_do(o, t, a, 1'b1);
    cmp_pc(pc, exp);
  endtask
  // drive pin selects and levels, then look at port b and pa7
  task automatic pins(input logic [12:0] s, input logic [6:0] p, input logic [7:0] pb, input logic pa7);
    @(posedge clk);
    sel <= s;
    per <= p;
    @(negedge clk);
    cmp_data(pb_out & 8'hf2, pb);
    cmp_data(pb_oe & 8'hf2, 8'hf2);
    cmp_data({7'h00, pa_out[7] & pa_oe[7]}, {7'h00, pa7});
  endtask
  // closing report
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    rst = 1'b1;
    pa_in = 8'h96;
    pb_in = 8'h09;
    sel = 13'h0000;
    per = 7'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cmp_pc(pc, VEC_RESET);
    rd(page_r, OFF_STATUS, STATUS_RST);
    rd(page_f, 6'h05, DIR_RST);
    rd(page_r, OFF_PORT_A, 8'h96);
    // ram banks and mirrors
    wr(page_r, OFF_PTR, 8'h00);
    wr(page_r, 6'h12, 8'ha5);
    wr(page_r, OFF_PTR, 8'h40);
    wr(page_r, 6'h3f, 8'h3c);
    wr(page_r, OFF_PTR, 8'h80);
    rd(page_r, 6'h12, 8'ha5);
    wr(page_r, OFF_PTR, 8'hc0);
    rd(page_r, 6'h3f, 8'h3c);
    rd(page_r, OFF_PTR, 8'hc0);
    wr(page_r, OFF_PLCON, 8'h5a);
    wr(page_r, OFF_PTR, 8'h7f);
    rd(page_r, OFF_INDIRECT, 8'h3c);
    wr(page_r, OFF_INDIRECT, 8'h77);
    wr(page_r, OFF_PTR, 8'h40);
    rd(page_r, 6'h3f, 8'h77);
    // unimplemented places
    wr(page_r, OFF_HOLE_A, 8'hff);
    wr(page_r, OFF_HOLE_B, 8'hff);
    wr(page_f, 6'h00, 8'hff);
    rd(page_r, OFF_HOLE_A, 8'h00);
    rd(page_r, OFF_HOLE_B, 8'h00);
    rd(page_f, 6'h00, 8'h00);
    // second and third pages ignore the bank bits
    wr(page_r, OFF_PTR, 8'hc0);
    wr(page_f, 6'h09, 8'h21);
    wr(page_s, 6'h0b, 8'h44);
    wr(page_r, OFF_PTR, 8'h00);
    rd(page_f, 6'h09, 8'h21);
    rd(page_s, 6'h0b, 8'h44);
    rd(page_r, OFF_PLCON, 8'h5a);
    rd(page_r, 6'h12, 8'ha5);
    // program counter
    op(op_long_jump, 10'h00e, 8'h00, 10'h00e);
    op(op_step, 10'h000, 8'h00, 10'h00f);
    u_core_model.pc_do(op_step, 10'h000, 8'h00, 1'b0);
    cmp_pc(pc, 10'h00f);
    op(op_long_call, 10'h3fd, 8'h00, 10'h3fd);
    op(op_return, 10'h000, 8'h00, 10'h010);
    wr(page_r, OFF_PC_HIGH, 8'h02);
    op(op_short_jump, 10'h155, 8'h00, 10'h355);
    wr(page_r, OFF_PC_HIGH, 8'h01);
    op(op_short_call, 10'h3ab, 8'h00, 10'h1ab);
    op(op_return, 10'h000, 8'h00, 10'h356);
    op(op_acc_jump, 10'h000, 8'h80, 10'h180);
    op(op_acc_call, 10'h000, 8'h7e, 10'h17e);
    op(op_sw_irq, 10'h000, 8'h00, VEC_SW_IRQ);
    op(op_hw_irq, 10'h000, 8'h00, VEC_HW_IRQ);
    op(op_return, 10'h000, 8'h00, 10'h002);
    op(op_return, 10'h000, 8'h00, 10'h17f);
    op(op_return, 10'h000, 8'h00, 10'h181);
    wr(page_r, OFF_PC_LOW, 8'h23);
    cmp_pc(pc, 10'h123);
    // external interrupt gating, every select pair
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      sel <= {11'h000, i[1:0]};
      @(negedge clk);
      cmp_data({7'h00, irq_lvl}, {7'h00, i == 3});
    end
    @(posedge clk);
    pa_in <= 8'h10;
    pb_in <= 8'h08;
    pins(13'h1dfc, 7'h55, 8'h62, 1'b0);
    cmp_data({4'h0, rst_pin_n, t01ck, t2ck, irsink}, 8'h07);
    pins(13'h1efc, 7'h2e, 8'h90, 1'b1);
    give_verdict();
  end
endmodule
